// ### src/pmux_pkg.sv
// Constants, types and line tables for the peripheral line mux.
// Function
// [R01] User peripheral decode only hits the upper window inclusive.
// [R02] Each user peripheral owns one contiguous 16-Kbyte slot.
// [R03] A peripheral identifier indexes its interrupt and clock gate.
// [R04] Parallel port controllers A to D carry identifiers 2 to 5.
// [R05] Serial controllers 0 to 2 carry identifiers 14 to 16.
// [R06] Each port controller has 32 lines, one bit position each.
// [R07] A line in peripheral mode routes only function A or B.
// [R08] Port C data lines 16 to 31 in I/O mode block 32-bit access.
// [R09] An I/O-reset line is an input with pull-up while in reset.
// [R10] An I/O-reset line resets its select status bit to 0.
// [R11] A function-reset line resets to it with select status 1.
// [R12] Address and chip-select lines drive their function at release.
// [R13] Function-reset lines also have the pull-up on after reset.
// [R14] Port A lines all reset as I/O with the listed A/B functions.
// [R15] Selecting a function absent on a line gives no drive.
package pmux_pkg;

  localparam int          LINES       = 32;
  localparam logic [31:0] USER_FIRST  = 32'hFFFA0000;
  localparam logic [31:0] USER_LAST   = 32'hFFFE3FFF;
  localparam int          SLOT_SHIFT  = 14;
  localparam logic [4:0]  PID_PORT_A  = 5'h02;
  localparam logic [4:0]  PID_SSC_0   = 5'h0E;
  localparam int          PORT_CNT    = 4;
  localparam int          SSC_CNT     = 3;

  // Reset and function-presence masks per port
  localparam logic [31:0] PA_RST_FUNC = 32'h00000000;
  localparam logic [31:0] PA_HAS_A    = 32'hFFFFFFFF;
  localparam logic [31:0] PA_HAS_B    = 32'hFFFFFFFF;
  localparam logic [31:0] PC_RST_FUNC = 32'h00003F80;
  localparam logic [31:0] PC_HAS_A    = 32'hFFFF3FFF;
  localparam logic [31:0] PC_HAS_B    = 32'h00000000;
  localparam logic [31:0] PC_DATA_HI  = 32'hFFFF0000;
  localparam logic [31:0] RST_PULLUP  = 32'hFFFFFFFF;
  localparam logic [31:0] RST_ZERO    = 32'h00000000;

  typedef struct packed {
    logic [31:0] func_set;
    logic [31:0] gpio_set;
    logic [31:0] asel_set;
    logic [31:0] bsel_set;
    logic [31:0] pu_on;
    logic [31:0] pu_off;
    logic [31:0] out_set;
    logic [31:0] out_clr;
    logic [31:0] oe_set;
    logic [31:0] oe_clr;
  } pmux_ctl_s;

  typedef struct packed {
    logic [31:0] func_en;
    logic [31:0] sel_b;
    logic [31:0] pull_en;
    logic [31:0] gpio_out;
    logic [31:0] gpio_oe;
  } pmux_port_s;

endpackage : pmux_pkg

// ### src/pmux_top.sv
// Line mux for ports A and C, window decode and identifier routing.
module pmux_port
  import pmux_pkg::*;
#(
  parameter logic [31:0] RST_FUNC = RST_ZERO,
  parameter logic [31:0] HAS_A    = PA_HAS_A,
  parameter logic [31:0] HAS_B    = PA_HAS_B
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Software controls
  input  wire pmux_ctl_s   ctl,
  // Peripheral side
  input  wire logic [31:0] fa_out,
  input  wire logic [31:0] fa_oe,
  input  wire logic [31:0] fb_out,
  input  wire logic [31:0] fb_oe,
  output logic      [31:0] fa_in,
  output logic      [31:0] fb_in,
  // Pad side
  input  wire logic [31:0] pin_in,
  output logic      [31:0] pin_out,
  output logic      [31:0] pin_oe,
  output logic      [31:0] pin_pull,
  // Status
  output logic      [31:0] peripheral_select_status,
  output logic      [31:0] sel_b_status
);

  pmux_port_s  st_ff;
  pmux_port_s  nxt_st;
  logic [31:0] use_a;
  logic [31:0] use_b;

  // ****************************************
  // State update
  // ****************************************
  // Set wins over clear on each pair
  always_comb begin
    nxt_st = st_ff;
    nxt_st.func_en  = (st_ff.func_en & ~ctl.gpio_set) | ctl.func_set;
    nxt_st.sel_b    = (st_ff.sel_b & ~ctl.asel_set) | ctl.bsel_set;
    nxt_st.pull_en  = (st_ff.pull_en & ~ctl.pu_off) | ctl.pu_on;
    nxt_st.gpio_out = (st_ff.gpio_out & ~ctl.out_clr) | ctl.out_set;
    nxt_st.gpio_oe  = (st_ff.gpio_oe & ~ctl.oe_clr) | ctl.oe_set;
  end

  // [R09] Async reset to input with pull-up
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // [R10] [R11] Select status from reset table
      st_ff.func_en  <= RST_FUNC;
      st_ff.sel_b    <= RST_ZERO;
      // [R13] Pull-up on for every line
      st_ff.pull_en  <= RST_PULLUP;
      st_ff.gpio_out <= RST_ZERO;
      st_ff.gpio_oe  <= RST_ZERO;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Line routing
  // ****************************************
  // [R07] One function per line
  // [R15] Absent function gives no drive
  assign use_a = st_ff.func_en & ~st_ff.sel_b & HAS_A;
  assign use_b = st_ff.func_en & st_ff.sel_b & HAS_B;

  // [R06] One bit position per line
  // [R12] Combinational so drive starts at release
  assign pin_out = (use_a & fa_out) | (use_b & fb_out)
                 | (~st_ff.func_en & st_ff.gpio_out);
  assign pin_oe  = (use_a & fa_oe) | (use_b & fb_oe)
                 | (~st_ff.func_en & st_ff.gpio_oe);
  assign pin_pull = st_ff.pull_en;
  assign fa_in = pin_in & use_a;
  assign fb_in = pin_in & use_b;
  assign peripheral_select_status = st_ff.func_en;
  assign sel_b_status = st_ff.sel_b;

  // ****************************************
  // Checks
  // ****************************************
  logic [31:0] gpio_only;
  assign gpio_only = ctl.gpio_set & ~ctl.func_set;

  sequence s_release;
    $fell(rst);
  endsequence

  sequence s_func_req;
    ctl.func_set != RST_ZERO;
  endsequence

  a_reset_status: assert property ( // [R10]
    @(posedge ref_clk) s_release |-> st_ff.func_en == RST_FUNC)
    else $error("select status wrong after reset");

  a_reset_pullup: assert property ( // [R13]
    @(posedge ref_clk) s_release |-> pin_pull == RST_PULLUP
      && (pin_oe & ~RST_FUNC) == RST_ZERO)
    else $error("pull-up or drive wrong after reset");

  a_func_set: assert property ( // [R11]
    @(posedge ref_clk) disable iff (rst)
    s_func_req |=> (st_ff.func_en & $past(ctl.func_set))
      == $past(ctl.func_set))
    else $error("function select lost");

  a_gpio_clear: assert property ( // [R09]
    @(posedge ref_clk) disable iff (rst)
    gpio_only != RST_ZERO |=>
      (st_ff.func_en & $past(gpio_only)) == RST_ZERO)
    else $error("I/O mode not taken");

  a_absent_func: assert property ( // [R15]
    @(posedge ref_clk) disable iff (rst)
    (pin_oe & st_ff.func_en & st_ff.sel_b & ~HAS_B) == RST_ZERO
      && (pin_oe & st_ff.func_en & ~st_ff.sel_b & ~HAS_A)
      == RST_ZERO)
    else $error("absent function drives line");

  a_route_one: assert property ( // [R07]
    @(posedge ref_clk) disable iff (rst)
    (fa_in & fb_in) == RST_ZERO
      && (pin_out & use_b) == (fb_out & use_b))
    else $error("line routes two functions");

  a_gpio_drive: assert property ( // [R06]
    @(posedge ref_clk) disable iff (rst)
    (pin_oe & ~st_ff.func_en) == (st_ff.gpio_oe & ~st_ff.func_en))
    else $error("I/O line drive wrong");

  // Pull-up stays on and I/O-reset lines stay undriven for the whole reset, not only at release
  a_reset_hold: assert property ( // [R09]
    @(posedge ref_clk) rst |-> pin_pull == RST_PULLUP
      && (pin_oe & ~RST_FUNC) == RST_ZERO)
    else $error("I/O line driven in reset");

  a_bsel_take: assert property ( // [R07]
    @(posedge ref_clk) disable iff (rst)
    ctl.bsel_set != RST_ZERO |=>
      (st_ff.sel_b & $past(ctl.bsel_set)) == $past(ctl.bsel_set))
    else $error("function B select lost");

endmodule : pmux_port

module pmux_top
  import pmux_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Address decode
  input  wire logic [31:0] addr,
  output logic             user_hit,
  output logic      [4:0]  user_slot,
  // Identifier routing
  input  wire logic [3:0]  port_irq,
  input  wire logic [2:0]  ssc_irq,
  input  wire logic [31:0] clk_gate,
  output logic      [31:0] irq_src,
  output logic      [3:0]  port_clk_en,
  output logic      [2:0]  ssc_clk_en,
  // Port A
  input  wire pmux_ctl_s   a_ctl,
  input  wire logic [31:0] a_fa_out,
  input  wire logic [31:0] a_fa_oe,
  input  wire logic [31:0] a_fb_out,
  input  wire logic [31:0] a_fb_oe,
  output logic      [31:0] a_fa_in,
  output logic      [31:0] a_fb_in,
  input  wire logic [31:0] a_pin_in,
  output logic      [31:0] a_pin_out,
  output logic      [31:0] a_pin_oe,
  output logic      [31:0] a_pin_pull,
  output logic      [31:0] a_psr,
  output logic      [31:0] a_selb,
  // Port C
  input  wire pmux_ctl_s   c_ctl,
  input  wire logic [31:0] c_fa_out,
  input  wire logic [31:0] c_fa_oe,
  output logic      [31:0] c_fa_in,
  input  wire logic [31:0] c_pin_in,
  output logic      [31:0] c_pin_out,
  output logic      [31:0] c_pin_oe,
  output logic      [31:0] c_pin_pull,
  output logic      [31:0] c_psr,
  // Memory interface width
  output logic             wide_ok
);

  logic [31:0] offs;
  logic [31:0] c_sel_b;

  // ****************************************
  // Window decode
  // ****************************************
  // [R01] Inclusive user window
  assign user_hit = (addr >= USER_FIRST) && (addr <= USER_LAST);
  assign offs     = addr - USER_FIRST;
  // [R02] 16-Kbyte slot per peripheral
  assign user_slot = user_hit ? offs[SLOT_SHIFT +: 5] : 5'h00;

  // ****************************************
  // Identifier routing
  // ****************************************
  // [R03] Identifier indexes irq and clock gate
  always_comb begin
    irq_src = RST_ZERO;
    // [R04] Ports A to D at 2 to 5
    irq_src[PID_PORT_A +: PORT_CNT] = port_irq;
    // [R05] Serial 0 to 2 at 14 to 16
    irq_src[PID_SSC_0 +: SSC_CNT] = ssc_irq;
  end
  assign port_clk_en = clk_gate[PID_PORT_A +: PORT_CNT];
  assign ssc_clk_en  = clk_gate[PID_SSC_0 +: SSC_CNT];

  // ****************************************
  // Ports
  // ****************************************
  // [R14] Port A resets all lines as I/O
  pmux_port #(
    .RST_FUNC (PA_RST_FUNC),
    .HAS_A    (PA_HAS_A),
    .HAS_B    (PA_HAS_B)
  ) u_port_a (
    .ref_clk                  (ref_clk),
    .rst                      (rst),
    .ctl                      (a_ctl),
    .fa_out                   (a_fa_out),
    .fa_oe                    (a_fa_oe),
    .fb_out                   (a_fb_out),
    .fb_oe                    (a_fb_oe),
    .fa_in                    (a_fa_in),
    .fb_in                    (a_fb_in),
    .pin_in                   (a_pin_in),
    .pin_out                  (a_pin_out),
    .pin_oe                   (a_pin_oe),
    .pin_pull                 (a_pin_pull),
    .peripheral_select_status (a_psr),
    .sel_b_status             (a_selb)
  );

  // Port C has no B functions at all
  pmux_port #(
    .RST_FUNC (PC_RST_FUNC),
    .HAS_A    (PC_HAS_A),
    .HAS_B    (PC_HAS_B)
  ) u_port_c (
    .ref_clk                  (ref_clk),
    .rst                      (rst),
    .ctl                      (c_ctl),
    .fa_out                   (c_fa_out),
    .fa_oe                    (c_fa_oe),
    .fb_out                   (RST_ZERO),
    .fb_oe                    (RST_ZERO),
    .fa_in                    (c_fa_in),
    .fb_in                    (),
    .pin_in                   (c_pin_in),
    .pin_out                  (c_pin_out),
    .pin_oe                   (c_pin_oe),
    .pin_pull                 (c_pin_pull),
    .peripheral_select_status (c_psr),
    .sel_b_status             (c_sel_b)
  );

  // [R08] Upper data lines must all be bus function
  assign wide_ok = ((c_psr & ~c_sel_b & PC_DATA_HI) == PC_DATA_HI);

  // ****************************************
  // Checks
  // ****************************************
  // Window edges sit on slot bounds, so slot numbers suffice
  a_window_edge: assert property ( // [R01]
    @(posedge ref_clk) disable iff (rst)
    user_hit == (addr[31:14] >= USER_FIRST[31:14]
      && addr[31:14] <= USER_LAST[31:14]))
    else $error("window decode wrong");

  a_slot_size: assert property ( // [R02]
    @(posedge ref_clk) disable iff (rst)
    user_hit |-> user_slot == offs[18:14])
    else $error("slot index wrong");

  a_slot_miss: assert property ( // [R02]
    @(posedge ref_clk) disable iff (rst)
    !user_hit |-> user_slot == 5'h00)
    else $error("slot index outside window");

  a_wide_block: assert property ( // [R08]
    @(posedge ref_clk) disable iff (rst)
    ((c_psr & PC_DATA_HI) != PC_DATA_HI) |-> !wide_ok)
    else $error("wide access not blocked");

  a_id_route: assert property ( // [R05]
    @(posedge ref_clk) disable iff (rst)
    irq_src[16:14] == ssc_irq && irq_src[5:2] == port_irq
      && ssc_clk_en == clk_gate[16:14])
    else $error("identifier routing wrong");

  a_rst_addr: assert property ( // [R12]
    @(posedge ref_clk) $fell(rst) |->
      (c_pin_oe & PC_RST_FUNC) == (c_fa_oe & PC_RST_FUNC))
    else $error("address lines not driven");

endmodule : pmux_top

// ### verification/pmux_pad_model.sv
// Pad and external device model for one 32-line port.
module pmux_pad_model (
  // Clock
  input  wire logic        ref_clk,
  // Design side
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] pin_pull,
  // External device
  input  wire logic [31:0] ext_val,
  input  wire logic [31:0] ext_oe,
  output logic      [31:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] float_ff;
  // Unpulled floating lines toggle so a stale level never passes
  initial float_ff = 32'h00000000;
  always @(posedge ref_clk) float_ff <= ~float_ff;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
                | (~pin_oe & ~ext_oe & (pin_pull | float_ff));
endmodule : pmux_pad_model

// ### verification/test_pmux_top.sv
// Self-checking bench for the peripheral line mux.
module test_pmux_top
  import pmux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, user_hit, wide_ok;
  logic [4:0] user_slot;
  logic [3:0] port_irq, port_clk_en;
  logic [2:0] ssc_irq, ssc_clk_en;
  logic [31:0] addr, clk_gate, irq_src, a_fa_out, a_fa_oe, a_fb_out, a_fb_oe;
  logic [31:0] a_fa_in, a_fb_in, a_pin_in, a_pin_out, a_pin_oe, a_pin_pull;
  logic [31:0] a_psr, a_selb, c_fa_out, c_fa_oe, c_fa_in, c_pin_in;
  logic [31:0] c_pin_out, c_pin_oe, c_pin_pull, c_psr, a_ext, a_eoe;
  logic [31:0] c_ext, c_eoe, m;
  pmux_ctl_s  a_ctl, c_ctl;
  pmux_port_s ea, ec;
  int seed, error_cnt, num_checks, i, k;
  // Lines 14 and 15 of port C carry no function
  localparam logic [31:0] C_HAS_A = 32'hFFFF3FFF;
  logic [31:0] corner [6] = '{32'hFFF9FFFF, 32'hFFFA0000, 32'hFFFA4000,
                              32'hFFFE3FFF, 32'hFFFE4000, 32'h0FFA0000};

  pmux_top DUT (.ref_clk, .rst, .addr, .user_hit, .user_slot, .port_irq,
    .ssc_irq, .clk_gate, .irq_src, .port_clk_en, .ssc_clk_en, .a_ctl,
    .a_fa_out, .a_fa_oe, .a_fb_out, .a_fb_oe, .a_fa_in, .a_fb_in, .a_pin_in,
    .a_pin_out, .a_pin_oe, .a_pin_pull, .a_psr, .a_selb, .c_ctl, .c_fa_out,
    .c_fa_oe, .c_fa_in, .c_pin_in, .c_pin_out, .c_pin_oe, .c_pin_pull,
    .c_psr, .wide_ok);
  pmux_pad_model pad_a (.ref_clk, .pin_out(a_pin_out), .pin_oe(a_pin_oe),
    .pin_pull(a_pin_pull), .ext_val(a_ext), .ext_oe(a_eoe), .pin_in(a_pin_in));
  pmux_pad_model pad_c (.ref_clk, .pin_out(c_pin_out), .pin_oe(c_pin_oe),
    .pin_pull(c_pin_pull), .ext_val(c_ext), .ext_oe(c_eoe), .pin_in(c_pin_in));

  always #10 ref_clk = ~ref_clk;

  // ***********************
  // Expectation functions
  // ***********************
  function automatic pmux_port_s rst_st(input logic [31:0] f);
    return '{f, 32'h0, 32'hFFFFFFFF, 32'h0, 32'h0};
  endfunction : rst_st

  // Set wins over clear in the same cycle
  function automatic logic [31:0] upd(input logic [31:0] s, c, q);
    return s | (q & ~c);
  endfunction : upd

  function automatic pmux_port_s step(input pmux_ctl_s c, pmux_port_s e);
    return '{upd(c.func_set, c.gpio_set, e.func_en),
             upd(c.bsel_set, c.asel_set, e.sel_b),
             upd(c.pu_on, c.pu_off, e.pull_en),
             upd(c.out_set, c.out_clr, e.gpio_out),
             upd(c.oe_set, c.oe_clr, e.gpio_oe)};
  endfunction : step

  function automatic logic [31:0] route(input pmux_port_s e,
      input logic [31:0] ha, hb, fa, fb, gp);
    return (e.func_en & ~e.sel_b & ha & fa)
         | (e.func_en & e.sel_b & hb & fb) | (~e.func_en & gp);
  endfunction : route

  task automatic chk(input string n, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic check_all();
    chk("a_psr", ea.func_en, a_psr);
    chk("a_selb", ea.sel_b, a_selb);
    chk("a_pull", ea.pull_en, a_pin_pull);
    m = route(ea, '1, '1, a_fa_oe, a_fb_oe, ea.gpio_oe);
    chk("a_oe", m, a_pin_oe);
    m = route(ea, '1, '1, a_fa_out, a_fb_out, ea.gpio_out);
    chk("a_out", m, a_pin_out);
    // Unrouted lines must read zero on the function side
    m = ea.func_en & ~ea.sel_b;
    chk("a_fa_in", a_pin_in & m, a_fa_in);
    m = ea.func_en & ea.sel_b;
    chk("a_fb_in", a_pin_in & m, a_fb_in);
    chk("c_psr", ec.func_en, c_psr);
    chk("c_pull", ec.pull_en, c_pin_pull);
    m = route(ec, C_HAS_A, '0, c_fa_oe, '0, ec.gpio_oe);
    chk("c_oe", m, c_pin_oe);
    m = route(ec, C_HAS_A, '0, c_fa_out, '0, ec.gpio_out);
    chk("c_out", m, c_pin_out);
    m = ec.func_en & ~ec.sel_b & C_HAS_A;
    chk("c_fa_in", c_pin_in & m, c_fa_in);
    m = ec.func_en & ~ec.sel_b;
    chk("wide_ok", {31'h0, &m[31:16]}, {31'h0, wide_ok});
    m = (addr >= 32'hFFFA0000 && addr <= 32'hFFFE3FFF) ? 32'h1 : 32'h0;
    chk("user_hit", m, {31'h0, user_hit});
    m = m[0] ? (addr - 32'hFFFA0000) >> 14 : 32'h0;
    chk("user_slot", m, {27'h0, user_slot});
    m = {15'h0, ssc_irq, 8'h0, port_irq, 2'h0};
    chk("irq_src", m, irq_src);
    m = {28'h0, clk_gate[5:2]};
    chk("port_clk", m, {28'h0, port_clk_en});
    m = {29'h0, clk_gate[16:14]};
    chk("ssc_clk", m, {29'h0, ssc_clk_en});
  endtask : check_all

  task automatic drive(input int n);
    for (k = 0; k < 10; k++) begin
      a_ctl[k*32 +: 32] = $random(seed) & $random(seed);
      c_ctl[k*32 +: 32] = $random(seed) & $random(seed);
    end
    // Full data-high function A selection, the only way wide access returns
    if (n % 16 == 5) begin
      c_ctl = '0;
      c_ctl.func_set = 32'hFFFF0000;
      c_ctl.asel_set = 32'hFFFF0000;
    end
    addr = (n < 6) ? corner[n] : (n % 2) ? $random(seed)
         : 32'hFFF00000 | ($random(seed) & 32'h000FFFFF);
    clk_gate = $random(seed);
    {port_irq, ssc_irq} = 7'($random(seed));
    // Independent draws so drive, enable and far side never track
    {a_fa_out, a_fa_oe} = {$random(seed), $random(seed)};
    {a_fb_out, a_fb_oe} = {$random(seed), $random(seed)};
    {c_fa_out, c_fa_oe} = {$random(seed), $random(seed)};
    {a_ext, a_eoe} = {$random(seed), $random(seed)};
    {c_ext, c_eoe} = {$random(seed), $random(seed)};
  endtask : drive

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // ***********************
  // Main sequence
  // ***********************
  initial begin
    seed = 19630;
    error_cnt = 0;
    num_checks = 0;
    ref_clk = 0;
    rst = 1;
    drive(0);
    ea = rst_st(32'h0);
    ec = rst_st(32'h00003F80);
    repeat (7) @(posedge ref_clk);
    #1 check_all();
    @(posedge ref_clk);
    #1 rst = 0;
    for (i = 0; i < 600; i++) begin
      drive(i);
      @(posedge ref_clk);
      #1;
      ea = step(a_ctl, ea);
      ec = step(c_ctl, ec);
      check_all();
      // Reset in mid-run must take effect without a clock edge
      if (i == 300) begin
        rst = 1;
        #1;
        ea = rst_st(32'h0);
        ec = rst_st(32'h00003F80);
        check_all();
        @(posedge ref_clk);
        #1 rst = 0;
      end
    end
    finish_test();
  end

  initial begin
    #40000;
    error_cnt++;
    finish_test();
  end
endmodule : test_pmux_top
